// ---- hw/kbse_pkg.sv ----
// constants and the serial state enum shared by the keyboard scan encoder
// assumes a 100 MHz core clock; all counts are derived from it here
package kbse_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // bus cycle of a 3.840 MHz crystal divided by four
  localparam int BUS_CYC_NS = 1040;
  localparam int BUS_CYC = BUS_CYC_NS / CLK_PERIOD_NS;
  localparam int TICK_DIV = 100;
  localparam int CLICK_MS = 10;
  localparam int CLICK_CYC_DEF = CLICK_MS * 1000000 / CLK_PERIOD_NS;

  // address regions by a[15:14]; a[13:12] split the rom region
  localparam logic [1:0] RGN_OPT = 2'h1;
  localparam logic [1:0] RGN_PORT = 2'h2;
  localparam logic [1:0] RGN_ROM = 2'h3;
  localparam logic [15:0] VEC_BASE = 16'hFFF8;
  localparam int RAM_BYTES = 128;
  localparam int RAM_AW = 7;
  localparam logic RAM_EN = 1'b1;

  // option switch fields, closed reads 0
  localparam int OPT_BAUD_LSB = 0;
  localparam int OPT_PAR_EN = 3;
  localparam int OPT_PAR_ODD = 4;
  localparam int OPT_STOP2 = 5;

  localparam logic [5:0] SHIFT_KEY = 6'h3E;
  localparam logic [5:0] CTRL_KEY = 6'h3F;
  localparam logic [7:0] MOD_COLS = 8'hC0;
  localparam logic [5:0] NUM_LETTERS = 6'h1A;
  localparam logic [5:0] NUM_DIGITS = 6'h0A;
  localparam logic [7:0] ASC_A = 8'h61;
  localparam logic [7:0] ASC_0 = 8'h30;
  localparam logic [7:0] ASC_PUNCT = 8'h3A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CTRL_MASK = 8'h1F;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PAR = 3'b011,
    SER_STOP = 3'b100
  } kbse_ser_e;
endpackage

// ---- hw/kbse_buf.sv ----
// small flop fifo with valid/ready on both sides
// assumes one clock; push and pop may coincide
`timescale 1ns/10ps
module kbse_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= bump(wr_ptr_r);
      if (pop) rd_ptr_r <= bump(rd_ptr_r);
      cnt_r <= CW'(cnt_r + push - pop);
    end
  end
endmodule

// ---- hw/kbse_top.sv ----
// keyboard controller: bus decode, key matrix scan, ascii queue, serial out
// assumes bus inputs and key columns are synchronous to core_clk
//
// Contract
// - reset vectors at top of memory always land in the second rom
// - bus clock phase derived from crystal rate, 1.04 us per bus cycle
// - 128 bytes internal ram, always enabled, only read/write memory
// - selects only with address in range, qualifier high and phase high
// - option 4000-7FFF, port adapter 8000-BFFF, rom1 E000, rom2 at top
// - unused address lines ignored, devices alias inside their region
// - six-way option switch readable; closed reads 0, open reads 1
// - bus phase divided by 100 gives the 9.6 kHz tick
// - tick feeds the adapter control input that raises the interrupt
// - adapter ports drive rows, sense columns, make serial data and flags
// - serial output activity fires a click pulse for relay and led
// - rows driven to 1 in turn; pressed key reads column 0
// - 64 keys each addressed by a unique row and column
// - one read of a key is taken as valid, no debounce
// - press and release kept in a 64 bit table; shift/ctrl shape ascii
// - scan loops forever; at most one new character per full scan
// - queued characters shift out one bit per qualifying tick
`timescale 1ns/10ps
module kbse_top import kbse_pkg::*; #(
  parameter int CLICK_CYC = CLICK_CYC_DEF,
  parameter int TICK_N = TICK_DIV
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [15:0] bus_addr,
  input wire logic valid_bus_address_qualifier,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [5:0] opt_sw,
  input wire logic [7:0] col_in,
  input wire logic host_ready,
  output logic bus_phase_r,
  output logic sel_opt_r,
  output logic sel_port_r,
  output logic sel_rom1_r,
  output logic sel_rom2_r,
  output logic rd_valid_r,
  output logic [7:0] rd_data_r,
  output logic [7:0] row_drv_r,
  output logic port_control_input_a_r,
  output logic ser_out_r,
  output logic tx_busy_r,
  output logic click_r
);
  localparam logic [6:0] BUS_LAST = 7'(BUS_CYC - 1);
  localparam logic [6:0] BUS_HALF = 7'(BUS_CYC / 2);
  // divider must fit 7 bits; a shorter one only serves to speed up sims
  localparam logic [6:0] TICK_LAST = 7'(TICK_N - 1);
  localparam int CKW = $clog2(CLICK_CYC + 1);

  // bus phase and tick
  logic [6:0] bus_cnt_r;
  logic [6:0] tick_cnt_r;
  wire e_tick = (bus_cnt_r == BUS_LAST);
  wire tick = e_tick & (tick_cnt_r == TICK_LAST);
  wire [6:0] bus_cnt_nxt = e_tick ? 7'h00 : 7'(bus_cnt_r + 7'h01);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_cnt_r <= 7'h00;
      tick_cnt_r <= 7'h00;
      bus_phase_r <= 1'b0;
      port_control_input_a_r <= 1'b0;
    end else begin
      bus_cnt_r <= bus_cnt_nxt;
      bus_phase_r <= (bus_cnt_nxt >= BUS_HALF);
      if (e_tick) tick_cnt_r <= tick ? 7'h00 : 7'(tick_cnt_r + 7'h01);
      port_control_input_a_r <= tick;
    end
  end

  // address decode; only a[15:12] and a[15:7] are looked at
  wire qual = valid_bus_address_qualifier & bus_phase_r;
  wire [1:0] rgn = bus_addr[15:14];
  wire hit_opt = qual & (rgn == RGN_OPT);
  wire hit_port = qual & (rgn == RGN_PORT);
  wire hit_rom = qual & (rgn == RGN_ROM) & bus_addr[13];
  wire hit_rom2 = hit_rom & bus_addr[12];
  wire hit_rom1 = hit_rom & ~bus_addr[12];
  wire hit_ram = qual & RAM_EN & (bus_addr[15:7] == 9'h000);
  wire [RAM_AW-1:0] ram_idx = bus_addr[RAM_AW-1:0];
  logic [7:0] ram_r [RAM_BYTES];

  // ram contents are data, not control state: no reset
  always_ff @(posedge core_clk) begin
    if (hit_ram & bus_wr) ram_r[ram_idx] <= bus_wdata;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_opt_r <= 1'b0;
      sel_port_r <= 1'b0;
      sel_rom1_r <= 1'b0;
      sel_rom2_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      sel_opt_r <= hit_opt;
      sel_port_r <= hit_port;
      sel_rom1_r <= hit_rom1;
      sel_rom2_r <= hit_rom2;
      rd_valid_r <= (hit_opt | hit_ram) & ~bus_wr;
      rd_data_r <= hit_opt ? {2'b00, opt_sw} :
                   (hit_ram & ~bus_wr) ? ram_r[ram_idx] : 8'h00;
    end
  end

  // key matrix scan, one row per bus cycle
  logic [2:0] row_idx_r;
  logic [63:0] key_state_r;
  logic took_r;
  logic pend_v_r;
  logic [7:0] pend_d_r;
  wire f_in_ready;

  function automatic logic [2:0] hot_idx(input logic [7:0] v);
    hot_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) hot_idx = 3'(i);
    end
  endfunction

  function automatic logic [7:0] key_to_ascii(input logic [5:0] k,
                                              input logic sh, input logic ct);
    logic [7:0] a;
    a = 8'h00;
    if (k < NUM_LETTERS) begin
      a = 8'(ASC_A + {2'b00, k});
      if (sh) a = a & ~CASE_BIT;
    end else if (k < NUM_LETTERS + NUM_DIGITS) begin
      a = 8'(ASC_0 + {2'b00, k} - {2'b00, NUM_LETTERS});
    end else begin
      a = 8'(ASC_PUNCT + {2'b00, k} - {2'b00, NUM_LETTERS} - {2'b00, NUM_DIGITS});
    end
    key_to_ascii = ct ? (a & CTRL_MASK) : a;
  endfunction

  wire [7:0] pressed = ~col_in;
  wire [5:0] row_base = {row_idx_r, 3'b000};
  wire [7:0] old_row = key_state_r[row_base +: 8];
  wire [7:0] mod_row = (row_idx_r == 3'h7) ? MOD_COLS : 8'h00;
  // one key taken per scan; others stay unmarked and come next scan
  wire take_ok = ~took_r & ~pend_v_r;
  wire [7:0] cand = pressed & ~old_row & ~mod_row & {8{take_ok}};
  wire [7:0] pick = cand & 8'(~cand + 8'h01);
  wire [7:0] row_new = (old_row & pressed) | (pressed & mod_row) | pick;
  wire [5:0] key_idx = {row_idx_r, hot_idx(pick)};
  wire capture = e_tick & (pick != 8'h00);
  wire [7:0] asc = key_to_ascii(key_idx, key_state_r[SHIFT_KEY], key_state_r[CTRL_KEY]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      row_idx_r <= 3'h0;
      row_drv_r <= 8'h01;
      key_state_r <= 64'h0000_0000_0000_0000;
      took_r <= 1'b0;
    end else if (e_tick) begin
      key_state_r[row_base +: 8] <= row_new;
      row_idx_r <= 3'(row_idx_r + 3'h1);
      row_drv_r <= 8'h01 << 3'(row_idx_r + 3'h1);
      took_r <= (row_idx_r == 3'h7) ? 1'b0 : (took_r | capture);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_v_r <= 1'b0;
      pend_d_r <= 8'h00;
    end else if (capture) begin
      pend_v_r <= 1'b1;
      pend_d_r <= asc;
    end else if (f_in_ready) begin
      pend_v_r <= 1'b0;
    end
  end

  // character queue
  wire f_valid;
  wire [7:0] f_data;
  logic [2:0] ser_state_r;
  wire f_pop = (ser_state_r == SER_IDLE) & port_control_input_a_r & f_valid & host_ready;

  kbse_buf #(.W(8), .DEPTH(2)) u_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(pend_v_r),
    .in_ready(f_in_ready),
    .in_data(pend_d_r),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // serial framer, stepped only by the tick
  logic [7:0] shreg_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] div_r;
  logic par_r;
  logic [CKW-1:0] click_cnt_r;
  wire [7:0] div_load = 8'(8'h01 << opt_sw[OPT_BAUD_LSB +: 3]) - 8'h01;
  wire bit_end = port_control_input_a_r & (div_r == 8'h00);
  wire [2:0] stop_xtra = {2'b00, opt_sw[OPT_STOP2]};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_state_r <= SER_IDLE;
      ser_out_r <= 1'b1;
      shreg_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      div_r <= 8'h00;
      par_r <= 1'b0;
    end else if (f_pop) begin
      ser_state_r <= SER_START;
      ser_out_r <= 1'b0;
      shreg_r <= f_data;
      bit_cnt_r <= 3'h0;
      div_r <= div_load;
      par_r <= opt_sw[OPT_PAR_ODD];
    end else if (bit_end && ser_state_r != SER_IDLE) begin
      div_r <= div_load;
      unique case (ser_state_r)
        SER_START, SER_DATA: begin
          if (ser_state_r == SER_DATA && bit_cnt_r == 3'h7) begin
            ser_state_r <= opt_sw[OPT_PAR_EN] ? SER_PAR : SER_STOP;
            ser_out_r <= opt_sw[OPT_PAR_EN] ? par_r : 1'b1;
            bit_cnt_r <= stop_xtra;
          end else begin
            ser_state_r <= SER_DATA;
            ser_out_r <= shreg_r[0];
            par_r <= par_r ^ shreg_r[0];
            shreg_r <= {1'b0, shreg_r[7:1]};
            if (ser_state_r == SER_DATA) bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
          end
        end
        SER_PAR: begin
          ser_state_r <= SER_STOP;
          ser_out_r <= 1'b1;
        end
        SER_STOP: begin
          if (bit_cnt_r != 3'h0) bit_cnt_r <= 3'(bit_cnt_r - 3'h1);
          else ser_state_r <= SER_IDLE;
        end
        default: ser_state_r <= SER_IDLE;
      endcase
    end else if (port_control_input_a_r && div_r != 8'h00) begin
      div_r <= 8'(div_r - 8'h01);
    end
  end

  // click: retriggerable, so a fast burst reads as one long click
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      click_cnt_r <= '0;
      click_r <= 1'b0;
      tx_busy_r <= 1'b0;
    end else begin
      click_cnt_r <= f_pop ? CKW'(CLICK_CYC - 1) :
                     (click_cnt_r != '0) ? CKW'(click_cnt_r - 1'b1) : click_cnt_r;
      click_r <= f_pop | (click_cnt_r != '0);
      tx_busy_r <= (ser_state_r != SER_IDLE);
    end
  end

  // checks
  logic [7:0] gap_r;
  logic seen_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= port_control_input_a_r ? {7'h00, e_tick} : 8'(gap_r + e_tick);
      seen_r <= seen_r | port_control_input_a_r;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sel_qual_a: assert property (
    (sel_opt_r | sel_port_r | sel_rom1_r | sel_rom2_r)
      |-> $past(valid_bus_address_qualifier) && $past(bus_phase_r))
    else $error("select without qualifier and phase");
  opt_alias_a: assert property (
    sel_opt_r |-> $past(bus_addr[15:14]) == RGN_OPT)
    else $error("option select outside its region");
  vec_rom2_a: assert property (
    (qual && bus_addr >= VEC_BASE) |=> sel_rom2_r && !sel_rom1_r)
    else $error("vector fetch not from second rom");
  opt_read_a: assert property (
    (sel_opt_r && rd_valid_r) |-> rd_data_r == {2'b00, $past(opt_sw)})
    else $error("option read value wrong");
  tick_gap_a: assert property (
    (port_control_input_a_r && seen_r && !$past(port_control_input_a_r))
      |-> gap_r == 8'(TICK_N))
    else $error("tick not every 100 bus cycles");
  row_hot_a: assert property ($onehot(row_drv_r))
    else $error("row drive not one hot");
  one_scan_a: assert property (capture |-> !took_r && !pend_v_r)
    else $error("second character in one scan");
  bit_step_a: assert property (
    $changed(ser_out_r) |-> $past(port_control_input_a_r))
    else $error("serial bit moved off a tick");
  start_bit_a: assert property (f_pop |=> !ser_out_r && tx_busy_r == 1'b0 ##1 tx_busy_r)
    else $error("start bit not sent");
  click_on_a: assert property (f_pop |=> click_r [*2])
    else $error("click not fired by serial output");

  key_cap_c: cover property (capture);
  char_out_c: cover property (f_pop ##1 ser_state_r == SER_START);
  queue_full_c: cover property (pend_v_r && !f_in_ready);
endmodule

// ---- test/kbse_host_model.sv ----
// host serial receiver model facing the keyboard serial output
// assumes 9600 baud, no parity, one stop bit, samples mid bit
`timescale 1ns/10ps
module kbse_host_model #(
  parameter int BIT_CYC = 10400
) (
  input wire logic core_clk,
  input wire logic ser_line,
  input wire logic hold_off,
  output logic host_ready,
  output logic [7:0] rx_data,
  output int rx_count,
  output logic stop_ok
);
  // host may refuse new characters while busy
  assign host_ready = !hold_off;
  initial begin
    rx_data = 8'h00;
    rx_count = 0;
    stop_ok = 1'b0;
    forever begin
      @(negedge ser_line);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      #1;
      // a glitch shorter than half a bit is not a start
      if (ser_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge core_clk);
          #1;
          rx_data[i] = ser_line;
        end
        repeat (BIT_CYC) @(posedge core_clk);
        #1;
        stop_ok = (ser_line === 1'b1);
        rx_count++;
      end
    end
  end
endmodule

// ---- test/kbse_top_tb.sv ----
// self-checking bench for the keyboard scan encoder
// assumes 100 MHz clock, key at row 0 col 0, shift at row 7 col 6, host model on serial out
`timescale 1ns/10ps
module kbse_top_tb import kbse_pkg::*; ();
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic qual = 1'b0;
  logic bus_wr = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [5:0] opt_sw = 6'h35;
  logic key_down = 1'b0;
  logic hold_off = 1'b1;
  logic shift_down = 1'b0;
  // a shorter tick keeps a whole serial frame inside the run budget
  localparam int TB_TICK = 10;
  logic [7:0] col_in;
  logic host_ready, bus_phase_r, sel_opt_r, sel_port_r, sel_rom1_r, sel_rom2_r;
  logic rd_valid_r, tick, ser_out_r, tx_busy_r, click_r, stop_ok;
  logic [7:0] rd_data_r, row_drv_r, rx_data;
  int rx_count, num_errors, checked, n, n2;
  logic [15:0] addr_t [10] = '{16'h4123, 16'h7FFF, 16'h8000, 16'hBFFE, 16'hE000,
    16'hEFFF, 16'hF000, 16'hFFFE, 16'hC000, 16'h2000};
  logic [3:0] sel_t [10] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0};

  always #5 core_clk = ~core_clk;
  assign col_in = (key_down && row_drv_r[0]) ? 8'hFE :
                  (shift_down && row_drv_r[7]) ? 8'hBF : 8'hFF;

  kbse_top #(.CLICK_CYC(8), .TICK_N(TB_TICK)) kbse_top_inst (.core_clk(core_clk),
    .arst_n(arst_n), .bus_addr(bus_addr), .valid_bus_address_qualifier(qual), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .opt_sw(opt_sw), .col_in(col_in), .host_ready(host_ready),
    .bus_phase_r(bus_phase_r), .sel_opt_r(sel_opt_r), .sel_port_r(sel_port_r),
    .sel_rom1_r(sel_rom1_r), .sel_rom2_r(sel_rom2_r), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .row_drv_r(row_drv_r), .port_control_input_a_r(tick),
    .ser_out_r(ser_out_r), .tx_busy_r(tx_busy_r), .click_r(click_r));

  kbse_host_model #(.BIT_CYC(TB_TICK * BUS_CYC)) kbse_host_model_inst (
    .core_clk(core_clk), .ser_line(ser_out_r),
    .hold_off(hold_off), .host_ready(host_ready), .rx_data(rx_data),
    .rx_count(rx_count), .stop_ok(stop_ok));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // bounded wait; a timeout shows up as a mismatch
  task automatic wait_lvl(input string name, ref logic sig, input logic lvl,
    input int lim, output int cnt);
    cnt = 0;
    while (sig !== lvl && cnt < lim) begin
      step(1);
      cnt++;
    end
    if (sig !== lvl) chk(name, 16'h0000, 16'h0001);
  endtask

  // request starts at the opening of a phase level, answer seen two edges on
  task automatic bus_acc(input logic [15:0] a, input logic q, input logic w,
    input logic hi);
    int c;
    wait_lvl("phase", bus_phase_r, !hi, 200, c);
    wait_lvl("phase", bus_phase_r, hi, 200, c);
    bus_addr = a;
    qual = q;
    bus_wr = w;
    bus_wdata = 8'hA5;
    step(2);
  endtask

  task automatic bus_rel;
    qual = 1'b0;
    bus_wr = 1'b0;
    step(1);
  endtask

  initial begin
    step(8);
    arst_n = 1'b1;
    chk("reset", {row_drv_r, ser_out_r, tx_busy_r, click_r, tick}, 16'h0018);
    n = 0;
    while (row_drv_r === 8'h01 && n < 200) begin
      step(1);
      n++;
    end
    chk("row", row_drv_r, 16'h0002);
    wait_lvl("ph", bus_phase_r, 1'b1, 200, n);
    wait_lvl("ph", bus_phase_r, 1'b0, 200, n);
    wait_lvl("ph", bus_phase_r, 1'b1, 200, n2);
    chk("phase_per", 16'(n + n2), 16'(BUS_CYC));
    for (int i = 0; i < 10; i++) begin
      bus_acc(addr_t[i], 1'b1, 1'b0, 1'b1);
      chk("sel", {sel_opt_r, sel_port_r, sel_rom1_r, sel_rom2_r}, sel_t[i]);
      if (i < 2) chk("opt_rd", {rd_valid_r, rd_data_r}, 16'h0135);
      if (i > 7) chk("unmapped", {rd_valid_r, rd_data_r}, 16'h0000);
      bus_rel();
    end
    bus_acc(16'hFFF8, 1'b1, 1'b0, 1'b1);
    chk("vector", sel_rom2_r, 16'h0001);
    bus_rel();
    bus_acc(16'h4000, 1'b0, 1'b0, 1'b1);
    chk("no_qual", {sel_opt_r, rd_valid_r}, 16'h0000);
    bus_rel();
    bus_acc(16'h4000, 1'b1, 1'b0, 1'b0);
    chk("phase_lo", {sel_opt_r, rd_valid_r}, 16'h0000);
    bus_rel();
    bus_acc(16'h0010, 1'b1, 1'b1, 1'b1);
    bus_rel();
    bus_acc(16'h0010, 1'b1, 1'b0, 1'b1);
    chk("ram", {rd_valid_r, rd_data_r}, 16'h01A5);
    bus_rel();
    opt_sw = 6'h00;
    wait_lvl("tick", tick, 1'b1, 11000, n);
    step(1);
    wait_lvl("tick", tick, 1'b1, 11000, n);
    chk("tick_per", 16'(n + 1), 16'(TB_TICK * BUS_CYC));
    key_down = 1'b1;
    step(2000);
    key_down = 1'b0;
    wait_lvl("tick", tick, 1'b1, 11000, n);
    step(2);
    chk("held", {ser_out_r, tx_busy_r, click_r}, 16'h0004);
    hold_off = 1'b0;
    wait_lvl("start", ser_out_r, 1'b0, 11000, n);
    chk("click_on", click_r, 16'h0001);
    step(7);
    chk("busy_click", {tx_busy_r, click_r}, 16'h0003);
    step(1);
    chk("click_off", click_r, 16'h0000);
    wait_lvl("bit0", ser_out_r, 1'b1, 11000, n);
    chk("start_len", 16'(n + 8), 16'(TB_TICK * BUS_CYC));
    n = 0;
    while (rx_count == 0 && n < 100000) begin
      step(1);
      n++;
    end
    chk("char", {stop_ok, rx_data}, 16'h0161);
    wait_lvl("idle", tx_busy_r, 1'b0, 11000, n);
    wait_lvl("tick", tick, 1'b1, 11000, n);
    step(2);
    chk("one_char", {15'(rx_count), ser_out_r}, 16'h0003);
    shift_down = 1'b1;
    step(1000);
    key_down = 1'b1;
    step(2000);
    key_down = 1'b0;
    n = 0;
    while (rx_count < 2 && n < 20000) begin
      step(1);
      n++;
    end
    chk("shift_char", {stop_ok, rx_data}, 16'h0141);
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
endmodule
